/* acrc_map.svh */
`ifndef ACRC_MAP_SVH
`define ACRC_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACRC_OFF_SC1 12'h000
`define ACRC_OFF_SC2 12'h004
`define ACRC_OFF_RH 12'h008
`define ACRC_OFF_RL 12'h00C
`define ACRC_OFF_CVH 12'h010
`define ACRC_OFF_CVL 12'h014
`define ACRC_OFF_CFG 12'h018
// ****************************************************************
// Field positions
// ****************************************************************
`define ACRC_SC1_CFLAG 7
`define ACRC_SC1_CONT 5
`define ACRC_SC2_ACT 7
`define ACRC_SC2_TRG 6
`define ACRC_SC2_CFE 5
`define ACRC_SC2_CFGT 4
`define ACRC_CFG_LP 7
`define ACRC_CFG_DIV_HI 6
`define ACRC_CFG_DIV_LO 5
`define ACRC_CFG_LSMP 4
`define ACRC_CFG_MODE_HI 3
`define ACRC_CFG_MODE_LO 2
`define ACRC_CFG_ICLK_HI 1
`define ACRC_CFG_ICLK_LO 0
// ****************************************************************
// Reset values and codes
// ****************************************************************
`define ACRC_SC1_RST 8'h1F
`define ACRC_CFG_RST 8'h00
`define ACRC_CHAN_OFF 5'h1F
`define ACRC_MODE_10 2'h2
// ****************************************************************
// Conversion timing in converter clock cycles
// ****************************************************************
`define ACRC_SAMPLE_SHORT 6'h04
`define ACRC_SAMPLE_LONG 6'h18
`define ACRC_CONV_OVH 6'h02
`define ACRC_BITS_8 6'h08
`define ACRC_BITS_10 6'h0A
`endif

/* acrc_pkg.sv */
`default_nettype none
package acrc_pkg;
  typedef enum logic [1:0] {
    ACRC_SRC_BUS,
    ACRC_SRC_BUS_HALF,
    ACRC_SRC_ALT,
    ACRC_SRC_ASYNC
  } acrc_src_t;
  typedef struct packed {
    logic [6:0] sc1;
    logic cflag;
    logic act;
    logic trg;
    logic cfe;
    logic cfgt;
    logic [1:0] cvh;
    logic [7:0] cvl;
    logic [7:0] cfg;
    logic [1:0] rh;
    logic [7:0] rl;
    logic lock;
    logic [5:0] cnt;
    logic [2:0] div;
    logic half;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ck_pulse;
    logic start;
  } acrc_state_t;
endpackage : acrc_pkg
`default_nettype wire

/* acrc_ctrl.sv */
`include "acrc_map.svh"
`default_nettype none
// Behaviour
// - Active bit in control two rises at start, falls at finish or abort unless a new conversion starts in that cycle.
// - Trigger select 0 starts on control one write; 1 starts on trigger.
// - Control two bit 5 enables the automatic compare.
// - Polarity 0 true when result below value; 1 when at or above.
// - Result high holds bits 9:8; 8-bit loads write it zero.
// - Results load each completion unless compare enabled and false, or 10-bit interlocked.
// - 10-bit: reading high blocks transfers until low read; drop results.
// - 8-bit: no read interlock, transfers never blocked.
// - Mode change drops the interlock; results keep their stale values.
// - High compare bits used only in 10-bit mode with compare on.
// - Low compare bits compared with result bits 7:0 in both modes.
// - Configuration bit 7 selects high speed or reduced power.
// - Divide field 6:5 divides the input clock by 1, 2, 4 or 8.
// - Configuration bit 4 selects short or long sample period.
// - Mode 00 is 8-bit, 10 is 10-bit; 01 and 11 are reserved.
// - Clock field 1:0: bus, bus halved, alternate, asynchronous.
// - Control one write aborts; restarts only with trigger select 0 and channel not all ones.
// - Complete flag sets always without compare, else only when true.
// - Complete flag clears on control one write or result low read.
module acrc_ctrl
  import acrc_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger and clock pins
  input wire logic hardware_trigger_in,
  input wire logic alternate_clock,
  input wire logic async_clock,
  // Analog core
  input wire logic [9:0] sar_code_in,
  output logic converter_clock,
  output logic conversion_start,
  output logic conversion_active,
  output logic [4:0] channel_select,
  output logic low_power_select,
  output logic long_sample_select
);
  // ****************************************************************
  // State
  // ****************************************************************
  acrc_state_t st_reg;
  acrc_state_t st_next;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] rd_val;
  logic sc1_wr;
  logic cfg_wr;
  logic rd_rh;
  logic rd_rl;
  logic mode10;
  logic chan_on;
  logic hw_edge;
  logic src_tick;
  logic [2:0] div_lim;
  logic sw_start;
  logic hw_start;
  logic cont_start;
  logic start;
  logic done;
  logic [9:0] code;
  logic [9:0] cmp_val;
  logic cond;
  logic hit;
  logic load;
  logic [5:0] conv_len;

  assign acc = psel && penable && st_reg.pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign sc1_wr = wr && (paddr == `ACRC_OFF_SC1);
  assign cfg_wr = wr && (paddr == `ACRC_OFF_CFG);
  assign rd_rh = rd && (paddr == `ACRC_OFF_RH);
  assign rd_rl = rd && (paddr == `ACRC_OFF_RL);
  assign mode10 = st_reg.cfg[`ACRC_CFG_MODE_HI:`ACRC_CFG_MODE_LO] ==
                  `ACRC_MODE_10;
  assign chan_on = st_reg.sc1[4:0] != `ACRC_CHAN_OFF;
  assign hw_edge = st_reg.s2[0] && !st_reg.s3[0];

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  always_comb
  begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (paddr)
      `ACRC_OFF_SC1: rd_val = {st_reg.cflag, st_reg.sc1};
      `ACRC_OFF_SC2: rd_val = {st_reg.act, st_reg.trg, st_reg.cfe,
                               st_reg.cfgt, 4'h0};
      `ACRC_OFF_RH: rd_val = {6'h00, st_reg.rh};
      `ACRC_OFF_RL: rd_val = st_reg.rl;
      `ACRC_OFF_CVH: rd_val = {6'h00, st_reg.cvh};
      `ACRC_OFF_CVL: rd_val = st_reg.cvl;
      `ACRC_OFF_CFG: rd_val = st_reg.cfg;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Converter clock source and divider
  // ****************************************************************
  always_comb
  begin
    case (acrc_src_t'(st_reg.cfg[`ACRC_CFG_ICLK_HI:`ACRC_CFG_ICLK_LO]))
      ACRC_SRC_BUS: src_tick = 1'b1;
      ACRC_SRC_BUS_HALF: src_tick = st_reg.half;
      ACRC_SRC_ALT: src_tick = st_reg.s2[1] && !st_reg.s3[1];
      ACRC_SRC_ASYNC: src_tick = st_reg.s2[2] && !st_reg.s3[2];
      default: src_tick = 1'b1;
    endcase
    case (st_reg.cfg[`ACRC_CFG_DIV_HI:`ACRC_CFG_DIV_LO])
      2'h0: div_lim = 3'h0;
      2'h1: div_lim = 3'h1;
      2'h2: div_lim = 3'h3;
      default: div_lim = 3'h7;
    endcase
  end

  // ****************************************************************
  // Conversion control and compare
  // ****************************************************************
  assign sw_start = sc1_wr && !st_reg.trg &&
                    (pwdata[4:0] != `ACRC_CHAN_OFF);
  assign hw_start = st_reg.trg && hw_edge && chan_on && !st_reg.act;
  assign done = st_reg.act && st_reg.ck_pulse && (st_reg.cnt == 6'h01) &&
                !sc1_wr;
  assign cont_start = done && st_reg.sc1[`ACRC_SC1_CONT] && chan_on;
  assign start = sw_start || hw_start || cont_start;
  assign conv_len = (st_reg.cfg[`ACRC_CFG_LSMP] ? `ACRC_SAMPLE_LONG
                     : `ACRC_SAMPLE_SHORT)
                    + (mode10 ? `ACRC_BITS_10 : `ACRC_BITS_8)
                    + `ACRC_CONV_OVH;
  // Compare value high bits only matter in 10-bit mode
  assign code = mode10 ? sar_code_in : {2'h0, sar_code_in[7:0]};
  assign cmp_val = mode10 ? {st_reg.cvh, st_reg.cvl}
                   : {2'h0, st_reg.cvl};
  assign cond = st_reg.cfgt ? (code >= cmp_val) : (code < cmp_val);
  assign hit = !st_reg.cfe || cond;
  assign load = done && hit && !(st_reg.lock && mode10);

  always_comb
  begin
    st_next = st_reg;
    // Pin synchronisers: stage one feeds stage two only
    st_next.s1 = {async_clock, alternate_clock, hardware_trigger_in};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.half = !st_reg.half;
    st_next.ck_pulse = 1'b0;
    if (src_tick)
    begin
      if (st_reg.div >= div_lim)
      begin
        st_next.div = 3'h0;
        st_next.ck_pulse = 1'b1;
      end
      else
      begin
        st_next.div = st_reg.div + 3'h1;
      end
    end
    // APB: one wait state, effects at the completing edge
    st_next.pready = psel && penable && !st_reg.pready;
    st_next.pslverr = psel && penable && !st_reg.pready && !mapped;
    if (psel && penable && !st_reg.pready)
    begin
      st_next.prdata = {24'h000000, rd_val};
    end
    if (wr)
    begin
      case (paddr)
        `ACRC_OFF_SC1: st_next.sc1 = pwdata[6:0];
        `ACRC_OFF_SC2:
        begin
          // Bits 3:0 are reserved and ignored
          st_next.trg = pwdata[`ACRC_SC2_TRG];
          st_next.cfe = pwdata[`ACRC_SC2_CFE];
          st_next.cfgt = pwdata[`ACRC_SC2_CFGT];
        end
        `ACRC_OFF_CVH: st_next.cvh = pwdata[1:0];
        `ACRC_OFF_CVL: st_next.cvl = pwdata[7:0];
        `ACRC_OFF_CFG: st_next.cfg = pwdata[7:0];
        default: st_next.cfg = st_reg.cfg;
      endcase
    end
    // Conversion sequencer
    if (st_reg.act && st_reg.ck_pulse && !done)
    begin
      st_next.cnt = st_reg.cnt - 6'h01;
    end
    if (sc1_wr || done)
    begin
      st_next.act = 1'b0;
    end
    if (start)
    begin
      st_next.act = 1'b1;
      st_next.cnt = conv_len;
    end
    st_next.start = start;
    // Result transfer
    if (load)
    begin
      st_next.rl = code[7:0];
      st_next.rh = mode10 ? code[9:8] : 2'h0;
    end
    // Interlock; a mode change drops it and leaves stale results
    if (rd_rl || cfg_wr)
    begin
      st_next.lock = 1'b0;
    end
    if (rd_rh && mode10)
    begin
      st_next.lock = 1'b1;
    end
    // Complete flag: a set in the clearing cycle wins
    if (sc1_wr || rd_rl)
    begin
      st_next.cflag = 1'b0;
    end
    if (done && hit)
    begin
      st_next.cflag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.sc1 <= 7'(`ACRC_SC1_RST);
      st_reg.cfg <= `ACRC_CFG_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign converter_clock = st_reg.ck_pulse;
  assign conversion_start = st_reg.start;
  assign conversion_active = st_reg.act;
  assign channel_select = st_reg.sc1[4:0];
  assign low_power_select = st_reg.cfg[`ACRC_CFG_LP];
  assign long_sample_select = st_reg.cfg[`ACRC_CFG_LSMP];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_act_start;
    start |=> conversion_active && conversion_start;
  endproperty
  a_act_start: assert property (p_act_start)
    else $error("active not set at start");

  property p_act_end;
    (done || sc1_wr) && !start |=> !conversion_active;
  endproperty
  a_act_end: assert property (p_act_end)
    else $error("active not cleared at end or abort");

  property p_sw_trig;
    sc1_wr && !st_reg.trg && pwdata[4:0] != `ACRC_CHAN_OFF
      |=> conversion_active ##0 st_reg.cnt == $past(conv_len);
  endproperty
  a_sw_trig: assert property (p_sw_trig)
    else $error("software write did not start a conversion");

  property p_hw_ignored;
    st_reg.trg && !conversion_active && !hw_edge && !sc1_wr
      |=> !conversion_active;
  endproperty
  a_hw_ignored: assert property (p_hw_ignored)
    else $error("conversion started without a trigger");

  property p_rh_8bit;
    !mode10 && !cfg_wr |=> st_reg.rh == 2'h0 || $stable(st_reg.rh);
  endproperty
  a_rh_8bit: assert property (p_rh_8bit)
    else $error("result high nonzero after 8-bit load");

  property p_keep;
    done && st_reg.cfe && !cond |=> $stable(st_reg.rl) && $stable(st_reg.rh);
  endproperty
  a_keep: assert property (p_keep)
    else $error("results changed on false compare");

  property p_lock_drop;
    done && st_reg.lock && mode10 |=> $stable(st_reg.rl);
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("result transferred while interlocked");

  property p_no_lock8;
    !mode10 && !(rd_rh && mode10) |=> !st_reg.lock || mode10;
  endproperty
  a_no_lock8: assert property (p_no_lock8)
    else $error("interlock held in 8-bit mode");

  property p_load10;
    done && mode10 && !st_reg.lock && hit
      |=> {st_reg.rh, st_reg.rl} == $past(sar_code_in);
  endproperty
  a_load10: assert property (p_load10)
    else $error("10-bit result not loaded");

  property p_cflag_set;
    done && hit |=> st_reg.cflag;
  endproperty
  a_cflag_set: assert property (p_cflag_set)
    else $error("complete flag not set");

  property p_cflag_clr;
    (sc1_wr || rd_rl) && !(done && hit) |=> !st_reg.cflag;
  endproperty
  a_cflag_clr: assert property (p_cflag_clr)
    else $error("complete flag not cleared");

  property p_apb_wait;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("APB answer not one cycle after access");
endmodule : acrc_ctrl
`default_nettype wire

/* acrc_core_model.sv */
`default_nettype none
module acrc_core_model
(
  // Clock and converter handshake
  input wire logic clk_sys,
  input wire logic conversion_start,
  input wire logic conversion_active,
  input wire logic [9:0] next_code,
  output logic [9:0] sar_code_in,
  // Trigger and clock sources
  output logic hardware_trigger_in,
  output logic alternate_clock,
  output logic async_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held = 10'h000;
  // Code is only trustworthy while a conversion runs
  assign sar_code_in = conversion_active ? held : ~held;
  initial
  begin
    hardware_trigger_in = 1'b0;
    alternate_clock = 1'b0;
    async_clock = 1'b0;
  end
  // Source clocks keep their edges clear of the system clock edges
  initial
  begin
    #3;
    forever #24 alternate_clock = ~alternate_clock;
  end
  initial
  begin
    #5;
    forever #20 async_clock = ~async_clock;
  end
  always @(posedge clk_sys)
  begin
    if (conversion_start)
      held <= next_code;
  end
  task automatic fire();
    @(posedge clk_sys);
    hardware_trigger_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    hardware_trigger_in <= 1'b0;
  endtask : fire
endmodule : acrc_core_model
`default_nettype wire

/* tb_top.sv */
`default_nettype none
`include "acrc_map.svh"
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("unexpected at %0t: %0h vs %0h", $time, (a), (b)); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Signals, design and partner
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, trig, alt_clk, asy_clk, converter_clock;
  logic conversion_start, conversion_active;
  logic low_power_select, long_sample_select;
  logic [4:0] channel_select;
  logic [9:0] next_code = 10'h000;
  logic [9:0] sar_code_in;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int checked = 0;
  logic [31:0] tbl [7] = '{32'h080006A5, 32'h082004A5, 32'h082002A5,
    32'h083000A5, 32'h083006A5, 32'h003004A5, 32'h002000A5};
  always #4 clk_sys = ~clk_sys;
  acrc_ctrl DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hardware_trigger_in(trig),
    .alternate_clock(alt_clk), .async_clock(asy_clk),
    .sar_code_in(sar_code_in), .converter_clock(converter_clock),
    .conversion_start(conversion_start),
    .conversion_active(conversion_active),
    .channel_select(channel_select),
    .low_power_select(low_power_select),
    .long_sample_select(long_sample_select)
  );
  acrc_core_model u_core (
    .clk_sys(clk_sys), .conversion_start(conversion_start),
    .conversion_active(conversion_active), .next_code(next_code),
    .sar_code_in(sar_code_in), .hardware_trigger_in(trig),
    .alternate_clock(alt_clk), .async_clock(asy_clk)
  );
  // ****************************************************************
  // Bus and wait tasks
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic timeout();
    err_total++;
    summarize();
  endtask : timeout
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (n > 20) timeout();
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic wait_act(input logic v, input int lim);
    int n;
    n = 0;
    while (conversion_active !== v)
    begin
      @(posedge clk_sys);
      n++;
      if (n > lim) timeout();
    end
  endtask : wait_act
  task automatic conv(input logic [9:0] c);
    next_code <= c;
    wr(`ACRC_OFF_SC1, 32'h03);
    wait_act(1'b1, 20);
    wait_act(1'b0, 2000);
  endtask : conv
  task automatic per(output int p);
    p = 0;
    do
    begin
      @(posedge clk_sys);
      p++;
      if (p > 200) timeout();
    end
    while (converter_clock !== 1'b1);
  endtask : per
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    `CHK(channel_select, 5'h1F)
    rdchk(`ACRC_OFF_SC1, 32'h1F);
    rdchk(`ACRC_OFF_SC2, 32'h00);
    rdchk(`ACRC_OFF_CFG, 32'h00);
    apb(1'b0, 12'h01C, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("test reset done");
  endtask : t_reset
  task automatic t_8bit();
    conv(10'h2A5);
    rdchk(`ACRC_OFF_SC1, 32'h83);
    rdchk(`ACRC_OFF_RH, 32'h0);
    conv(10'h15A);
    rdchk(`ACRC_OFF_RL, 32'h5A);
    rdchk(`ACRC_OFF_SC1, 32'h03);
    conv(10'h2A5);
    wr(`ACRC_OFF_SC1, 32'h1F);
    rdchk(`ACRC_OFF_SC1, 32'h1F);
    $display("test 8-bit done");
  endtask : t_8bit
  task automatic t_10bit();
    wr(`ACRC_OFF_CFG, 32'h08);
    conv(10'h2A5);
    rdchk(`ACRC_OFF_RH, 32'h2);
    conv(10'h15A);
    rdchk(`ACRC_OFF_RL, 32'hA5);
    conv(10'h15A);
    rdchk(`ACRC_OFF_RH, 32'h1);
    rdchk(`ACRC_OFF_RL, 32'h5A);
    $display("test 10-bit done");
  endtask : t_10bit
  task automatic t_cmp();
    logic ld;
    logic [1:0] rh;
    logic [7:0] rl;
    wr(`ACRC_OFF_CVH, 32'h01);
    wr(`ACRC_OFF_CVL, 32'h80);
    rdchk(`ACRC_OFF_CVL, 32'h80);
    foreach (tbl[i])
    begin
      wr(`ACRC_OFF_CFG, {24'h0, tbl[i][31:24]});
      wr(`ACRC_OFF_SC2, {24'h0, tbl[i][23:16]});
      conv(tbl[i][9:0]);
      ld = tbl[i][10];
      if (ld)
      begin
        rh = tbl[i][27] ? tbl[i][9:8] : 2'b00;
        rl = tbl[i][7:0];
      end
      rdchk(`ACRC_OFF_SC1, {24'h0, ld, 7'h03});
      rdchk(`ACRC_OFF_RH, {30'h0, rh});
      rdchk(`ACRC_OFF_RL, {24'h0, rl});
    end
    wr(`ACRC_OFF_SC2, 32'h00);
    $display("test compare done");
  endtask : t_cmp
  task automatic t_hw();
    wr(`ACRC_OFF_CFG, 32'h00);
    wr(`ACRC_OFF_SC2, 32'h40);
    wr(`ACRC_OFF_SC1, 32'h03);
    repeat (20) @(posedge clk_sys);
    `CHK(conversion_active, 1'b0)
    u_core.fire();
    wait_act(1'b1, 20);
    rdchk(`ACRC_OFF_SC2, 32'hC0);
    wait_act(1'b0, 2000);
    rdchk(`ACRC_OFF_SC2, 32'h40);
    wr(`ACRC_OFF_SC2, 32'h00);
    $display("test trigger done");
  endtask : t_hw
  task automatic t_abort();
    wr(`ACRC_OFF_SC1, 32'h03);
    wait_act(1'b1, 20);
    repeat (5) @(posedge clk_sys);
    wr(`ACRC_OFF_SC1, 32'h1F);
    wait_act(1'b0, 4);
    rdchk(`ACRC_OFF_SC1, 32'h1F);
    wr(`ACRC_OFF_SC1, 32'h03);
    wait_act(1'b1, 20);
    repeat (6) @(posedge clk_sys);
    wr(`ACRC_OFF_SC1, 32'h03);
    repeat (8) @(posedge clk_sys);
    `CHK(conversion_active, 1'b1)
    wait_act(1'b0, 2000);
    $display("test abort done");
  endtask : t_abort
  task automatic t_len();
    int n;
    int e;
    logic [7:0] cf [4] = '{8'h00, 8'h10, 8'h08, 8'h18};
    foreach (cf[i])
    begin
      wr(`ACRC_OFF_CFG, {24'h0, cf[i]});
      wr(`ACRC_OFF_SC1, 32'h03);
      wait_act(1'b1, 20);
      e = (cf[i][4] ? `ACRC_SAMPLE_LONG : `ACRC_SAMPLE_SHORT)
          + (cf[i][3] ? `ACRC_BITS_10 : `ACRC_BITS_8) + `ACRC_CONV_OVH;
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
        if (n > 100) timeout();
      end
      while (conversion_active !== 1'b0);
      `CHK(n, e)
    end
    wr(`ACRC_OFF_CFG, 32'h00);
    wr(`ACRC_OFF_SC1, 32'h23);
    repeat (40) @(posedge clk_sys);
    `CHK(conversion_active, 1'b1)
    rdchk(`ACRC_OFF_SC1, 32'hA3);
    wr(`ACRC_OFF_SC1, 32'h1F);
    wait_act(1'b0, 4);
    rdchk(`ACRC_OFF_SC1, 32'h1F);
    $display("test length done");
  endtask : t_len
  task automatic t_clk();
    int p;
    int base [4] = '{1, 2, 6, 5};
    wr(`ACRC_OFF_CFG, 32'h90);
    repeat (2) @(posedge clk_sys);
    `CHK(low_power_select, 1'b1)
    `CHK(long_sample_select, 1'b1)
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 4; d++)
      begin
        wr(`ACRC_OFF_CFG, {25'h0, d[1:0], 3'b000, s[1:0]});
        per(p);
        per(p);
        per(p);
        `CHK(p, base[s] << d)
      end
    `CHK({low_power_select, long_sample_select}, 2'b00)
    $display("test clock done");
  endtask : t_clk
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_8bit();
    t_10bit();
    t_cmp();
    t_hw();
    t_abort();
    t_len();
    t_clk();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
